//--- dbs_pkg.sv
// Constants and carrier types for the burst-of-four common-I/O memory port
package dbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Organisation: 1 selects 36-bit words, 0 selects 18-bit words
  localparam bit DBS_ORG_X36 = 1'b1;
  localparam int DBS_LANE_W  = 9;
  localparam int DBS_DATA_W  = DBS_ORG_X36 ? 36 : 18;
  localparam int DBS_BE_W    = DBS_DATA_W / DBS_LANE_W;
  localparam int DBS_BADDR_W = DBS_ORG_X36 ? 17 : 18;
  localparam int DBS_BEAT_W  = 2;
  localparam int DBS_WADDR_W = DBS_BADDR_W + DBS_BEAT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Burst and latency, counted in link clock phase edges (true or comp rise); FIFO depth in entries, sync stages in reference clock cycles
  localparam logic [1:0] DBS_LAST_BEAT    = 2'h3;
  localparam int         DBS_PIPE_LEN     = 5;
  localparam int         DBS_RD_START_DLL = 4;
  localparam int         DBS_RD_START_BYP = 1;
  localparam int         DBS_WR_FIRST     = 1;
  localparam int         DBS_WR_LAST      = 4;
  localparam int         DBS_FIFO_DEPTH   = 16;
  localparam int         DBS_SYNC_STAGES  = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic                   valid;
    logic                   is_read;
    logic [DBS_BADDR_W-1:0] addr;
  } dbs_cmd_s;

  typedef struct packed {
    logic [DBS_WADDR_W-1:0] addr;
    logic [DBS_DATA_W-1:0]  data;
    logic [DBS_BE_W-1:0]    be_n;
  } dbs_wbeat_s;

  typedef enum {
    DBS_OB_IDLE,
    DBS_OB_DRIVE
  } dbs_ob_e;

endpackage

//--- dbs_sram_port.sv
// Burst-of-four common-I/O double-data-rate memory port with write buffer FIFO
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Write buffer FIFO
module dbs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] wp_nxt;
  logic [PW-1:0] rp_r;
  logic [PW-1:0] rp_nxt;
  logic [PW:0]   cnt_r;
  logic [PW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  always_comb begin
    in_ready_o  = (cnt_r != (PW+1)'(DEPTH));
    out_valid_o = (cnt_r != '0);
    out_data_o  = mem[rp_r];
    push        = in_valid_i & in_ready_o;
    pop         = out_valid_o & out_ready_i;
    wp_nxt      = push ? ((wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt      = pop ? ((rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt     = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage is not reset
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Memory port top
module dbs_sram_port
  import dbs_pkg::*;
#(
  parameter int FIFO_DEPTH = DBS_FIFO_DEPTH
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   k_clk_i,
  input  wire logic                   k_clk_n_i,
  input  wire logic                   dll_off_n_i,
  input  wire logic                   load_cmd_n_i,
  input  wire logic                   rd_wr_sel_i,
  input  wire logic [DBS_BADDR_W-1:0] sync_addr_i,
  input  wire logic [DBS_BE_W-1:0]    byte_enable_n_i,
  input  wire logic [DBS_DATA_W-1:0]  dq_i,
  output logic      [DBS_DATA_W-1:0]  dq_o,
  output logic                        dq_oe_o,
  output logic                        echo_clock_true_o,
  output logic                        echo_clock_comp_o,
  output logic                        read_data_valid_o,
  output logic                        wr_buf_ready_o
);
  localparam int IN_W = 5 + DBS_BADDR_W + DBS_BE_W + DBS_DATA_W;
  localparam int WB_W = $bits(dbs_wbeat_s);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, all pins but ref_clk_i and nrst_i share the same two-stage delay
  logic [IN_W-1:0]          in_s1_r;
  logic [IN_W-1:0]          in_s2_r;
  logic                     k_s;
  logic                     kn_s;
  logic                     dll_on_s;
  logic                     load_n_s;
  logic                     rw_s;
  logic [DBS_BADDR_W-1:0]   addr_s;
  logic [DBS_BE_W-1:0]      be_n_s;
  logic [DBS_DATA_W-1:0]    dq_s;

  always_ff @(posedge ref_clk_i) begin
    in_s1_r <= {k_clk_i, k_clk_n_i, dll_off_n_i, load_cmd_n_i, rd_wr_sel_i,
                sync_addr_i, byte_enable_n_i, dq_i};
    in_s2_r <= in_s1_r;
  end

  assign {k_s, kn_s, dll_on_s, load_n_s, rw_s, addr_s, be_n_s, dq_s} = in_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic                     k_d_r;
  logic                     kn_d_r;
  dbs_cmd_s                 pipe_r   [DBS_PIPE_LEN];
  dbs_cmd_s                 pipe_nxt [DBS_PIPE_LEN];
  dbs_ob_e                  ob_r;
  dbs_ob_e                  ob_nxt;
  logic [DBS_BEAT_W-1:0]    beat_r;
  logic [DBS_BEAT_W-1:0]    beat_nxt;
  logic [DBS_BADDR_W-1:0]   raddr_r;
  logic [DBS_BADDR_W-1:0]   raddr_nxt;
  logic                     echo_r;
  logic                     echo_n_r;
  logic                     oe_r;
  logic                     oe_nxt;
  logic                     vld_r;
  logic                     wbr_r;
  logic [DBS_DATA_W-1:0]    dq_r;

  logic                     k_rise;
  logic                     kn_rise;
  logic                     ph;
  logic                     fetch;
  logic [DBS_WADDR_W-1:0]   fetch_addr;
  logic                     rd_start;
  dbs_wbeat_s               push_beat;
  logic                     push_valid;
  logic                     push_ready;
  logic [WB_W-1:0]          pop_bits;
  dbs_wbeat_s               pop_beat;
  logic                     pop_valid;
  logic                     pop_ready;

  logic [DBS_DATA_W-1:0]    mem [2**DBS_WADDR_W];

  ////////////////////////////////////////////////////////////////////////////
  // Command pipeline and read burst sequencing
  always_comb begin
    k_rise     = k_s & ~k_d_r;
    kn_rise    = kn_s & ~kn_d_r;
    ph         = k_rise | kn_rise;
    pipe_nxt   = pipe_r;
    ob_nxt     = ob_r;
    beat_nxt   = beat_r;
    raddr_nxt  = raddr_r;
    fetch      = 1'b0;
    fetch_addr = {raddr_r, beat_r};
    push_valid = 1'b0;
    push_beat  = '0;
    // Bypass mode brings the read burst forward by one and a half cycles
    rd_start   = dll_on_s ? (pipe_r[DBS_RD_START_DLL].valid & pipe_r[DBS_RD_START_DLL].is_read)
                          : (pipe_r[DBS_RD_START_BYP].valid & pipe_r[DBS_RD_START_BYP].is_read);
    if (ph) begin
      for (int i = 1; i < DBS_PIPE_LEN; i++) begin
        pipe_nxt[i] = pipe_r[i-1];
      end
      pipe_nxt[0] = '0;
      if (k_rise && !load_n_s) begin
        pipe_nxt[0].valid   = 1'b1;
        pipe_nxt[0].is_read = rw_s;
        pipe_nxt[0].addr    = addr_s;
      end
      // Write beats land on the edges after their command, alternating phases
      for (int i = DBS_WR_FIRST; i <= DBS_WR_LAST; i++) begin
        if (pipe_r[i].valid && !pipe_r[i].is_read) begin
          push_valid     = 1'b1;
          push_beat.addr = {pipe_r[i].addr, DBS_BEAT_W'(i - DBS_WR_FIRST)};
          push_beat.data = dq_s;
          push_beat.be_n = be_n_s;
        end
      end
      if (rd_start) begin
        ob_nxt     = DBS_OB_DRIVE;
        beat_nxt   = '0;
        raddr_nxt  = pipe_r[dll_on_s ? DBS_RD_START_DLL : DBS_RD_START_BYP].addr;
        fetch      = 1'b1;
        fetch_addr = {raddr_nxt, beat_nxt};
      end else if (ob_r == DBS_OB_DRIVE && beat_r != DBS_LAST_BEAT) begin
        beat_nxt   = beat_r + 1'b1;
        fetch      = 1'b1;
        fetch_addr = {raddr_r, beat_nxt};
      end else begin
        ob_nxt = DBS_OB_IDLE;
      end
    end
    oe_nxt = (ob_nxt == DBS_OB_DRIVE);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      // Track the pin level so release never shows a false edge
      k_d_r   <= k_s;
      kn_d_r  <= kn_s;
      pipe_r  <= '{default: '0};
      ob_r    <= DBS_OB_IDLE;
      beat_r  <= '0;
      raddr_r <= '0;
      echo_r   <= 1'b0;
      echo_n_r <= 1'b1;
      oe_r     <= 1'b0;
      vld_r    <= 1'b0;
      wbr_r    <= 1'b1;
    end else begin
      k_d_r   <= k_s;
      kn_d_r  <= kn_s;
      pipe_r  <= pipe_nxt;
      ob_r    <= ob_nxt;
      beat_r  <= beat_nxt;
      raddr_r <= raddr_nxt;
      echo_r  <= k_s;
      echo_n_r <= ~k_s;
      oe_r    <= oe_nxt;
      vld_r   <= oe_nxt;
      wbr_r   <= push_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer: draining pauses on read fetch cycles, so a fetch never
  // races a commit; drain keeps pace with beats long before any read fetch
  assign pop_ready = ~fetch;
  assign pop_beat  = dbs_wbeat_s'(pop_bits);

  dbs_fifo #(
    .W     (WB_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_beat),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_bits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Array: masked commit and registered read out
  always_ff @(posedge ref_clk_i) begin
    if (pop_valid && pop_ready) begin
      for (int l = 0; l < DBS_BE_W; l++) begin
        if (!pop_beat.be_n[l]) begin
          mem[pop_beat.addr][l*DBS_LANE_W +: DBS_LANE_W] <= pop_beat.data[l*DBS_LANE_W +: DBS_LANE_W];
        end
      end
    end
    if (fetch) begin
      dq_r <= mem[fetch_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign dq_o              = dq_r;
  assign dq_oe_o           = oe_r;
  assign echo_clock_true_o = echo_r;
  assign echo_clock_comp_o = echo_n_r;
  assign read_data_valid_o = vld_r;
  assign wr_buf_ready_o    = wbr_r;
endmodule

//--- dbs_sram_port_asserts.sv
// Pin-level checks on the memory port
`timescale 1ns/100ps
module dbs_sram_port_asserts
  import dbs_pkg::*;
(
  input wire logic                  ref_clk_i,
  input wire logic                  nrst_i,
  input wire logic                  k_clk_i,
  input wire logic                  dll_off_n_i,
  input wire logic                  load_cmd_n_i,
  input wire logic                  rd_wr_sel_i,
  input wire logic [DBS_DATA_W-1:0] dq_o,
  input wire logic                  dq_oe_o,
  input wire logic                  echo_clock_true_o,
  input wire logic                  echo_clock_comp_o,
  input wire logic                  read_data_valid_o
);
  logic [1:0] k_q;
  logic       e_q;
  logic [2:0] n_beat;
  logic [5:0] rd_age;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Age saturates so a stray enable with no read behind it misses both windows
  always_ff @(posedge ref_clk_i) begin
    k_q <= {k_q[0], k_clk_i};
    e_q <= echo_clock_true_o;
    if (!nrst_i || !dq_oe_o) n_beat <= 3'h0;
    else if (echo_clock_true_o != e_q) n_beat <= n_beat + 3'h1;
    if (!nrst_i) rd_age <= 6'h3f;
    else if (k_q == 2'h1 && !load_cmd_n_i && rd_wr_sel_i) rd_age <= 6'h00;
    else if (rd_age != 6'h3f) rd_age <= rd_age + 6'h01;
  end
  a_valid_tracks_oe: assert property (read_data_valid_o == dq_oe_o)
    else $error("valid differs from output enable");
  a_echo_pair: assert property (echo_clock_comp_o == !echo_clock_true_o)
    else $error("echo clocks not complementary");
  a_dq_with_echo: assert property ($changed(dq_o) |-> $changed(echo_clock_true_o))
    else $error("read data moved off an echo edge");
  a_burst_four: assert property ($fell(dq_oe_o) |-> n_beat == 3'h4)
    else $error("read burst not four beats");
  a_oe_holds: assert property ($rose(dq_oe_o) |-> dq_oe_o [*8])
    else $error("output enable dropped early");
  a_lat_normal: assert property ($rose(dq_oe_o) && dll_off_n_i |-> rd_age inside {[6'h26:6'h2c]})
    else $error("normal read latency wrong");
  a_lat_bypass: assert property ($rose(dq_oe_o) && !dll_off_n_i |-> rd_age inside {[6'h0e:6'h14]})
    else $error("bypass read latency wrong");
  a_echo_free: assert property ($stable(echo_clock_true_o) [*8] |-> ##[1:8] $changed(echo_clock_true_o))
    else $error("echo clock stopped");
  c_rd_norm: cover property ($rose(dq_oe_o) && dll_off_n_i);
  c_rd_byp: cover property ($rose(dq_oe_o) && !dll_off_n_i);
  c_rd_end: cover property ($fell(dq_oe_o));
endmodule

//--- dbs_ctrl_model.sv
// Controller model on the link side of the memory port
`timescale 1ns/100ps
module dbs_ctrl_model
  import dbs_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic [DBS_DATA_W-1:0]  q_i,
  output logic                        k_clk_o,
  output logic                        k_clk_n_o,
  output logic                        load_cmd_n_o,
  output logic                        rd_wr_sel_o,
  output logic      [DBS_BADDR_W-1:0] sync_addr_o,
  output logic      [DBS_BE_W-1:0]    byte_enable_n_o,
  output logic      [DBS_DATA_W-1:0]  d_o
);
  logic nxt_true;
  initial begin
    k_clk_o = 1'b0;
    k_clk_n_o = 1'b1;
    load_cmd_n_o = 1'b1;
    rd_wr_sel_o = 1'b0;
    sync_addr_o = '0;
    byte_enable_n_o = '1;
    d_o = '0;
    nxt_true = 1'b1;
    #2.3;
    forever begin
      #40 k_clk_o = ~k_clk_o;
      k_clk_n_o = ~k_clk_n_o;
    end
  end
  // Update mid-phase so the port's slow edge sampling still sees stable inputs
  task automatic half();
    @(posedge k_clk_o or posedge k_clk_n_o);
    nxt_true = !k_clk_o;
    repeat (6) @(posedge ref_clk_i);
  endtask
  task automatic cmd(input logic rd, input logic [DBS_BADDR_W-1:0] a, input int lat,
                     input logic [4*DBS_DATA_W-1:0] wd, input logic [4*DBS_BE_W-1:0] be,
                     output logic [4*DBS_DATA_W-1:0] q);
    int e;
    half();
    while (!nxt_true) half();
    load_cmd_n_o <= 1'b0;
    rd_wr_sel_o  <= rd;
    sync_addr_o  <= a;
    half();
    load_cmd_n_o <= 1'b1;
    sync_addr_o  <= ~a;
    for (e = 1; e <= 8; e++) begin
      if (!rd && e >= 2 && e <= 5) begin
        d_o             <= wd[(e-2)*DBS_DATA_W +: DBS_DATA_W];
        byte_enable_n_o <= be[(e-2)*DBS_BE_W +: DBS_BE_W];
      end else begin
        d_o             <= ~d_o;
        byte_enable_n_o <= '1;
      end
      half();
      if (rd && e >= lat && e < lat + 4) q[(e-lat)*DBS_DATA_W +: DBS_DATA_W] = q_i;
    end
  endtask
endmodule

//--- dbs_sram_port_tb_top.sv
// Bench: row table of write/read bursts, then bypass and reset cases
`timescale 1ns/100ps
module dbs_sram_port_tb_top
  import dbs_pkg::*;
;
  typedef struct packed {
    logic [DBS_BADDR_W-1:0] a;
    logic [4*DBS_BE_W-1:0]  be;
  } dbs_row_s;
  localparam dbs_row_s ROWS [4] = '{'{17'h00000, 16'h0000}, '{17'h1ffff, 16'h0000},
                                   '{17'h00000, 16'h5af0}, '{17'h0a5a5, 16'h0000}};
  logic                  ref_clk, nrst, dll_off_n, k, kn, ld, rw, oe, et, ec, vld, rdy;
  logic [DBS_BADDR_W-1:0] addr;
  logic [DBS_BE_W-1:0]    be;
  logic [DBS_DATA_W-1:0]  cd, q, bus;
  logic [DBS_DATA_W-1:0]  mem [logic [DBS_WADDR_W-1:0]];
  int                     n_fail = 0, compares = 0, cyc = 0;
  assign bus = oe ? q : cd;
  dbs_sram_port #(.FIFO_DEPTH(DBS_FIFO_DEPTH)) dut (.ref_clk_i(ref_clk), .nrst_i(nrst),
    .k_clk_i(k), .k_clk_n_i(kn), .dll_off_n_i(dll_off_n), .load_cmd_n_i(ld), .rd_wr_sel_i(rw),
    .sync_addr_i(addr), .byte_enable_n_i(be), .dq_i(bus), .dq_o(q), .dq_oe_o(oe),
    .echo_clock_true_o(et), .echo_clock_comp_o(ec), .read_data_valid_o(vld),
    .wr_buf_ready_o(rdy));
  dbs_ctrl_model ctl (.ref_clk_i(ref_clk), .q_i(bus), .k_clk_o(k), .k_clk_n_o(kn),
    .load_cmd_n_o(ld), .rd_wr_sel_o(rw), .sync_addr_o(addr), .byte_enable_n_o(be), .d_o(cd));
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(input logic [DBS_DATA_W-1:0] got, input logic [DBS_DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rst_chk();
    #1;
    chk_bit(oe, 1'b0);
    chk_bit(vld, 1'b0);
    chk_bit(et, 1'b0);
    chk_bit(ec, 1'b1);
    chk_bit(rdy, 1'b1);
    $display("reset test done");
  endtask
  // Model applies lanes itself, so a masked beat must leave old lane data
  task automatic row_op(input int i, input int lat);
    logic [4*DBS_DATA_W-1:0] wd, rq;
    int b, l;
    for (b = 0; b < 4; b++)
      wd[b*DBS_DATA_W +: DBS_DATA_W] = {DBS_BE_W{9'h100 + 9'(4 * i + b)}};
    ctl.cmd(1'b0, ROWS[i].a, lat, wd, ROWS[i].be, rq);
    for (b = 0; b < 4; b++)
      for (l = 0; l < DBS_BE_W; l++)
        if (!ROWS[i].be[b*DBS_BE_W+l])
          mem[{ROWS[i].a, 2'(b)}][l*DBS_LANE_W +: DBS_LANE_W] =
            wd[b*DBS_DATA_W+l*DBS_LANE_W +: DBS_LANE_W];
    ctl.cmd(1'b1, ROWS[i].a, lat, wd, ROWS[i].be, rq);
    for (b = 0; b < 4; b++)
      chk_word(rq[b*DBS_DATA_W +: DBS_DATA_W], mem[{ROWS[i].a, 2'(b)}]);
    chk_bit(rdy, 1'b1);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      $display("ERROR %0t run timed out", $time);
      summarize();
    end
  end
  initial begin
    nrst = 1'b0;
    dll_off_n = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst_chk();
    @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (ROWS[i]) begin
      row_op(i, 5);
      $display("row %0d test done", i);
    end
    @(posedge ref_clk);
    dll_off_n <= 1'b0;
    row_op(3, 2);
    $display("bypass test done");
    @(posedge ref_clk);
    dll_off_n <= 1'b1;
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_chk();
    @(posedge ref_clk);
    nrst <= 1'b1;
    row_op(1, 5);
    $display("post reset test done");
    summarize();
  end
endmodule
bind dbs_sram_port dbs_sram_port_asserts u_chk (.ref_clk_i, .nrst_i, .k_clk_i, .dll_off_n_i,
  .load_cmd_n_i, .rd_wr_sel_i, .dq_o, .dq_oe_o, .echo_clock_true_o, .echo_clock_comp_o,
  .read_data_valid_o);
